// [fh_framer_tx.sv]
// Framer end: flow tagging, sequence numbering and fragmentation
`timescale 1ns/1ps
module fh_framer_tx #(
	parameter int NUM_FLOWS = 16, // Flows with their own counter and tag
	parameter int BLOCK_BYTES = 48 // Bytes in one resource block group unit
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic msg_valid_i,
	output logic msg_ready_o,
	input wire logic [fh_pkg::BYTE_W-1:0] msg_data_i,
	input wire logic msg_last_i,
	input wire logic msg_plane_i,
	input wire logic [fh_pkg::AC_W-1:0] antenna_carrier_id_i,
	input wire logic [fh_pkg::SECT_W-1:0] section_tag_i,
	input wire logic [fh_pkg::BLK_W-1:0] first_block_index_i,
	fh_link_if.tx link
);
	localparam int FI_W = $clog2(NUM_FLOWS); // Flow index width
	localparam logic [15:0] MTU_MIN = 16'(fh_pkg::TRANSPORT_OVH + BLOCK_BYTES);
	localparam logic [15:0] BLK_LAST = 16'(BLOCK_BYTES - 1);
	localparam logic [7:0] TAG_END = 8'(32'(fh_pkg::REG_TAG_BASE) + 4 * NUM_FLOWS);

	// Refuse sizes the address map or counters cannot hold
	generate
		if (NUM_FLOWS < 2 || NUM_FLOWS > 32 || (1 << FI_W) != NUM_FLOWS ||
			BLOCK_BYTES < 1 || BLOCK_BYTES > 1024) begin : g_bad_param
			$error("fh_framer_tx: unsupported NUM_FLOWS or BLOCK_BYTES");
		end
	endgenerate

	// Merge write data into a register by byte lanes
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0] ctrl; // Mode and identifier kind
	logic [15:0] net_mtu; // Network MTU in bytes
	logic [fh_pkg::TAG_W-1:0] tag_tbl [NUM_FLOWS]; // Identifier per flow
	logic [fh_pkg::SEQ_W-1:0] seq_mem [2*NUM_FLOWS]; // Counter per flow and plane
	logic [15:0] frag_bytes; // Bytes so far in this packet
	logic [15:0] blk_byte; // Byte position inside current block
	logic [15:0] piece_blocks; // Whole blocks so far in this piece
	logic [15:0] rel_block; // First block of this piece, from section start
	logic [fh_pkg::SUB_W-1:0] sub_cnt; // Next fragment number
	logic [15:0] msg_count; // Finished messages
	logic in_msg; // A message is in progress
	logic rd_ack; // Read answer cycle

	// Register decode
	wire is_ctrl = avs_address_i == fh_pkg::REG_CTRL;
	wire is_mtu = avs_address_i == fh_pkg::REG_MTU;
	wire is_status = avs_address_i == fh_pkg::REG_STATUS;
	wire is_tag = avs_address_i >= fh_pkg::REG_TAG_BASE && avs_address_i < TAG_END &&
		avs_address_i[1:0] == 2'h0;
	wire [7:0] tag_off = avs_address_i - fh_pkg::REG_TAG_BASE;
	wire [FI_W-1:0] tag_idx = tag_off[FI_W+1:2];
	wire [31:0] mtu_new = be_merge({16'h0000, net_mtu}, avs_writedata_i, avs_byteenable_i);
	// Tag write merged by byte lanes, low half kept
	wire [31:0] tag_new = be_merge({16'h0000, tag_tbl[tag_idx]}, avs_writedata_i,
		avs_byteenable_i);
	wire [31:0] status_v = {15'h0000, in_msg, msg_count};
	wire [31:0] rd_val = is_ctrl ? ctrl : is_mtu ? {16'h0000, net_mtu} :
		is_status ? status_v : is_tag ? {16'h0000, tag_tbl[tag_idx]} : 32'h0000_0000;

	// Reads wait one cycle, writes none
	assign avs_waitrequest_o = avs_read_i & ~rd_ack;

	// Byte path and sizing
	wire tr_mode = ctrl[fh_pkg::CTRL_TRANSPORT_BIT];
	wire [15:0] limit = net_mtu - 16'(fh_pkg::TRANSPORT_OVH);
	wire [15:0] max_blk = limit / 16'(BLOCK_BYTES);
	wire [FI_W-1:0] flow = antenna_carrier_id_i[FI_W-1:0];
	wire [FI_W:0] idx = {msg_plane_i, flow};
	assign msg_ready_o = ~link.valid | link.ready;
	wire acc = msg_valid_i & msg_ready_o;
	wire blk_done = blk_byte == BLK_LAST;
	wire frag_end = (frag_bytes == limit - 16'h0001) | msg_last_i;
	wire piece_end = (blk_done & (piece_blocks + 16'h0001 == max_blk)) | msg_last_i;
	wire pkt_end = tr_mode ? frag_end : piece_end;
	wire msg_done = tr_mode ? msg_last_i : pkt_end;
	wire [15:0] piece_len = piece_blocks + 16'h0001;

	// Register writes
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ctrl <= fh_pkg::CTRL_RESET;
			net_mtu <= fh_pkg::MTU_RESET;
			for (int i = 0; i < NUM_FLOWS; i++) begin
				tag_tbl[i] <= 16'h0000;
			end
		end else if (avs_write_i) begin
			if (is_ctrl) begin
				ctrl <= be_merge(ctrl, avs_writedata_i, avs_byteenable_i) & 32'h0000_0007;
			end
			// Too small an MTU is ignored so a block always fits
			if (is_mtu && mtu_new[15:0] >= MTU_MIN) begin
				net_mtu <= mtu_new[15:0];
			end
			if (is_tag) begin
				tag_tbl[tag_idx] <= tag_new[15:0];
			end
		end
	end

	// Read answer
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rd_ack <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			rd_ack <= avs_read_i & ~rd_ack;
			if (avs_read_i & ~rd_ack) begin
				avs_readdata_o <= rd_val;
			end
		end
	end

	// Sequence counters, wrap after 255
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 2 * NUM_FLOWS; i++) begin
				seq_mem[i] <= 8'h00;
			end
		end else if (acc && msg_done) begin
			seq_mem[idx] <= seq_mem[idx] + 8'h01;
		end
	end

	// Packet and block position counters
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			frag_bytes <= 16'h0000;
			blk_byte <= 16'h0000;
			piece_blocks <= 16'h0000;
			rel_block <= 16'h0000;
			sub_cnt <= 7'h00;
		end else if (acc) begin
			frag_bytes <= pkt_end ? 16'h0000 : frag_bytes + 16'h0001;
			blk_byte <= (blk_done | msg_last_i) ? 16'h0000 : blk_byte + 16'h0001;
			piece_blocks <= pkt_end ? 16'h0000 : piece_blocks + {15'h0000, blk_done};
			// Next piece starts after the blocks just sent
			if (msg_last_i) begin
				rel_block <= 16'h0000;
			end else if (!tr_mode && pkt_end) begin
				rel_block <= rel_block + piece_len;
			end
			// First fragment zero, then one more each
			if (msg_last_i) begin
				sub_cnt <= 7'h00;
			end else if (tr_mode && pkt_end) begin
				sub_cnt <= sub_cnt + 7'h01;
			end
		end
	end

	// Message status
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			in_msg <= 1'b0;
			msg_count <= 16'h0000;
		end else if (acc) begin
			in_msg <= ~msg_last_i;
			msg_count <= msg_count + {15'h0000, msg_done};
		end
	end

	// Link handshake
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			link.valid <= 1'b0;
		end else if (acc) begin
			link.valid <= 1'b1;
		end else if (link.ready) begin
			link.valid <= 1'b0;
		end
	end

	// Link byte and header fields
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			link.data <= 8'h00;
			link.last <= 1'b0;
			link.plane <= 1'b0;
			link.antenna_carrier_id <= 16'h0000;
			link.message_sequence_number <= 8'h00;
			link.last_fragment <= 1'b0;
			link.fragment_sequence_number <= 7'h00;
			link.section_tag <= 12'h000;
			link.first_block_index <= 10'h000;
			link.block_count <= 10'h000;
			link.flow_tag <= 16'h0000;
			link.tag_kind <= fh_pkg::TAG_VLAN;
		end else if (acc) begin
			link.data <= msg_data_i;
			link.last <= pkt_end;
			link.plane <= msg_plane_i;
			link.antenna_carrier_id <= antenna_carrier_id_i;
			link.message_sequence_number <= seq_mem[idx];
			link.last_fragment <= tr_mode ? msg_last_i : 1'b1;
			link.fragment_sequence_number <= tr_mode ? sub_cnt : 7'h00;
			link.section_tag <= section_tag_i;
			link.first_block_index <= first_block_index_i + rel_block[9:0];
			link.block_count <= piece_len[9:0];
			link.flow_tag <= tag_tbl[flow];
			link.tag_kind <= ctrl[fh_pkg::CTRL_KIND_LSB +: 2];
		end
	end
endmodule // fh_framer_tx

// [fh_pkg.sv]
// Shared constants for the fronthaul framer and reassembler
package fh_pkg;
	// Field widths on the link
	localparam int BYTE_W = 8; // Payload byte
	localparam int SEQ_W = 8; // Message sequence number
	localparam int SUB_W = 7; // Fragment sequence number
	localparam int AC_W = 16; // Antenna-carrier identifier
	localparam int SECT_W = 12; // Section tag
	localparam int BLK_W = 10; // Block index and count
	localparam int TAG_W = 16; // Transport identifier
	localparam int KIND_W = 2; // Transport identifier kind
	// Frame sizing
	localparam int ETH_PAYLOAD = 1500; // Standard frame payload bytes
	localparam int TRANSPORT_OVH = 8; // Transport overhead bytes
	localparam logic [15:0] MTU_RESET = 16'h05dc; // Network MTU after reset
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MTU = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_TAG_BASE = 8'h10;
	// Control fields
	localparam int CTRL_TRANSPORT_BIT = 0; // 1: transport fragmentation
	localparam int CTRL_KIND_LSB = 1; // Identifier kind, two bits
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Status fields
	localparam int STATUS_COUNT_LSB = 0; // Messages finished, 16 bits
	localparam int STATUS_BUSY_BIT = 16; // Message in progress
	// Kind of transport identifier used to separate flows
	typedef enum logic [KIND_W-1:0] {
		TAG_VLAN = 2'h0,
		TAG_MAC = 2'h1,
		TAG_ETHERTYPE = 2'h2,
		TAG_UDP = 2'h3
	} tag_kind_e;
endpackage

// [fh_link_if.sv]
// Packet link between the framer and the reassembler
`timescale 1ns/1ps
interface fh_link_if;
	logic valid; // Byte present
	logic ready; // Byte taken
	logic [fh_pkg::BYTE_W-1:0] data; // Payload byte
	logic last; // Last byte of a packet; header fields valid here
	logic plane; // 0 user, 1 control
	logic [fh_pkg::AC_W-1:0] antenna_carrier_id;
	logic [fh_pkg::SEQ_W-1:0] message_sequence_number;
	logic last_fragment; // Final packet of the message
	logic [fh_pkg::SUB_W-1:0] fragment_sequence_number;
	logic [fh_pkg::SECT_W-1:0] section_tag;
	logic [fh_pkg::BLK_W-1:0] first_block_index;
	logic [fh_pkg::BLK_W-1:0] block_count;
	logic [fh_pkg::TAG_W-1:0] flow_tag; // Transport identifier value
	logic [fh_pkg::KIND_W-1:0] tag_kind; // Which identifier it is
	// Framer end
	modport tx (output valid, data, last, plane, antenna_carrier_id, message_sequence_number,
		last_fragment, fragment_sequence_number, section_tag, first_block_index,
		block_count, flow_tag, tag_kind, input ready);
	// Reassembler end
	modport rx (input valid, data, last, plane, antenna_carrier_id, message_sequence_number,
		last_fragment, fragment_sequence_number, section_tag, first_block_index,
		block_count, flow_tag, tag_kind, output ready);
endinterface

// [fh_reassembler_rx.sv]
// Reassembler end: flow separation, fragment ordering and delivery
`timescale 1ns/1ps
module fh_reassembler_rx #(
	parameter int DEPTH = 4096 // Largest message in bytes
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	fh_link_if.rx link,
	input wire logic [fh_pkg::TAG_W-1:0] cu_tag_i,
	input wire logic baseband_role_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [fh_pkg::BYTE_W-1:0] out_data_o,
	output logic out_last_o,
	output logic [fh_pkg::AC_W-1:0] out_antenna_carrier_id_o,
	output logic [fh_pkg::TAG_W+fh_pkg::AC_W-1:0] out_endpoint_o,
	output logic [fh_pkg::SEQ_W-1:0] out_message_sequence_number_o,
	output logic loss_o,
	output logic mgmt_o
);
	localparam int PTR_W = $clog2(DEPTH);

	// Buffer must be a power of two of useful size
	generate
		if (DEPTH < 16 || (1 << PTR_W) != DEPTH) begin : g_bad_param
			$error("fh_reassembler_rx: DEPTH must be a power of two, 16 or more");
		end
	endgenerate

	// Idle, filling, sending
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_FILL = 2'b01,
		RX_SEND = 2'b11
	} rx_state_e;

	rx_state_e state; // Reassembly state
	logic [fh_pkg::BYTE_W-1:0] mem [DEPTH]; // Message store
	logic [PTR_W:0] wr_cnt; // Bytes stored
	logic ovf; // Message too long for the store
	logic [PTR_W-1:0] last_idx; // Index of final byte
	logic [PTR_W-1:0] rd_ptr; // Next byte to send
	logic pend; // Bytes left to send
	logic [fh_pkg::SUB_W-1:0] exp_sub; // Expected fragment number
	logic [fh_pkg::SEQ_W-1:0] cur_seq; // Sequence of message in progress

	// Beat decode
	assign link.ready = state != RX_SEND;
	wire beat = link.valid & link.ready;
	wire match = link.flow_tag == cu_tag_i;
	wire room = wr_cnt != (PTR_W+1)'(DEPTH);
	wire seq_ok = state == RX_IDLE || link.message_sequence_number == cur_seq;
	wire frag_ok = link.fragment_sequence_number == exp_sub && seq_ok && !ovf && room;
	wire pkt_end = beat & match & link.last;
	wire go_send = pkt_end & frag_ok & link.last_fragment;
	wire out_take = out_valid_o & out_ready_i;
	wire load = pend & (~out_valid_o | out_ready_i);

	// Store bytes of the user and control flow
	always_ff @(posedge mclk_i) begin
		if (beat && match && room) begin
			mem[wr_cnt[PTR_W-1:0]] <= link.data;
		end
	end

	// Fragment checking and state
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state <= RX_IDLE;
			wr_cnt <= '0;
			ovf <= 1'b0;
			exp_sub <= 7'h00;
			cur_seq <= 8'h00;
			loss_o <= 1'b0;
			mgmt_o <= 1'b0;
		end else begin
			loss_o <= pkt_end & ~frag_ok;
			mgmt_o <= beat & ~match & link.last;
			unique case (state)
				RX_IDLE, RX_FILL: begin
					if (pkt_end && !frag_ok) begin
						// Gap or misorder: discard the whole message
						state <= RX_IDLE;
						wr_cnt <= '0;
						ovf <= 1'b0;
						exp_sub <= 7'h00;
					end else if (go_send) begin
						state <= RX_SEND;
					end else if (pkt_end) begin
						state <= RX_FILL;
						exp_sub <= exp_sub + 7'h01;
						cur_seq <= link.message_sequence_number;
						wr_cnt <= wr_cnt + (PTR_W+1)'(1);
					end else if (beat && match) begin
						// Overlong message is marked and later dropped
						if (room) begin
							wr_cnt <= wr_cnt + (PTR_W+1)'(1);
						end else begin
							ovf <= 1'b1;
						end
					end
				end
				RX_SEND: begin
					if (out_take && out_last_o) begin
						state <= RX_IDLE;
						wr_cnt <= '0;
						exp_sub <= 7'h00;
					end
				end
				default: begin
					state <= RX_IDLE;
				end
			endcase
		end
	end

	// Header of a finished message
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			last_idx <= '0;
			out_antenna_carrier_id_o <= 16'h0000;
			out_endpoint_o <= 32'h0000_0000;
			out_message_sequence_number_o <= 8'h00;
		end else if (go_send) begin
			last_idx <= wr_cnt[PTR_W-1:0];
			out_antenna_carrier_id_o <= link.antenna_carrier_id;
			// Baseband side adds the transport identifier
			out_endpoint_o <= {baseband_role_i ? link.flow_tag : 16'h0000,
				link.antenna_carrier_id};
			out_message_sequence_number_o <= link.message_sequence_number;
		end
	end

	// Deliver stored bytes
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pend <= 1'b0;
			rd_ptr <= '0;
			out_valid_o <= 1'b0;
			out_data_o <= 8'h00;
			out_last_o <= 1'b0;
		end else if (go_send) begin
			pend <= 1'b1;
			rd_ptr <= '0;
		end else if (load) begin
			out_valid_o <= 1'b1;
			out_data_o <= mem[rd_ptr];
			out_last_o <= rd_ptr == last_idx;
			pend <= rd_ptr != last_idx;
			rd_ptr <= rd_ptr + PTR_W'(1);
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule // fh_reassembler_rx

// [fh_link_props.sv]
// Link checks between framer and reassembler
`timescale 1ns/1ps
module fh_link_props #(
	parameter int LIMIT = 1492 // Largest packet in bytes
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic valid,
	input wire logic ready,
	input wire logic [7:0] data,
	input wire logic last,
	input wire logic plane,
	input wire logic [15:0] antenna_carrier_id,
	input wire logic [7:0] message_sequence_number,
	input wire logic last_fragment,
	input wire logic [6:0] fragment_sequence_number,
	input wire logic [15:0] flow_tag
);
	wire acc = valid & ready; // Beat taken
	wire acc_end = acc & last; // Packet taken
	wire [4:0] fidx = {plane, antenna_carrier_id[3:0]}; // Plane and flow
	logic [15:0] cnt; // Beats taken in this packet
	logic [6:0] exp_sub; // Expected fragment number
	logic [7:0] mseq; // Sequence of open message
	logic [7:0] lseq [32]; // Last sequence per flow
	logic [31:0] seen; // Flow has sent a message
	// Beat counter and fragment tracking
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cnt <= '0;
			exp_sub <= '0;
		end else if (acc) begin
			cnt <= last ? 16'h0 : cnt + 16'h1;
			if (last) exp_sub <= last_fragment ? 7'h0 : fragment_sequence_number + 7'h1;
		end
	end
	// Sequence memory per flow
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			seen <= '0;
		end else if (acc_end && fragment_sequence_number == 7'h0) begin
			seen[fidx] <= 1'b1;
			lseq[fidx] <= message_sequence_number;
			mseq <= message_sequence_number;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sequence held_beat;
		valid && !ready;
	endsequence
	sequence end_beat;
		valid && ready && last;
	endsequence
	hold_fields_a: assert property (held_beat |=> valid && $stable(data) && $stable(last)
		&& $stable(message_sequence_number) && $stable(fragment_sequence_number))
		else $error("link beat changed before taken");
	drop_after_take_a: assert property ($fell(valid) |-> $past(ready))
		else $error("valid dropped before taken");
	frag_order_a: assert property (end_beat |-> fragment_sequence_number == exp_sub)
		else $error("fragment number out of order");
	frag_same_seq_a: assert property (end_beat ##0 exp_sub != 7'h0
		|-> message_sequence_number == mseq) else $error("fragment sequence changed");
	packet_size_a: assert property (acc |-> cnt < LIMIT)
		else $error("packet longer than limit");
	flow_seq_a: assert property (end_beat ##0 (fragment_sequence_number == 7'h0
		&& seen[fidx]) |-> message_sequence_number == lseq[fidx] + 8'h01)
		else $error("sequence did not step by one");
	packet_fields_a: assert property (acc && !last |=> !valid || ($stable(plane)
		&& $stable(antenna_carrier_id) && $stable(flow_tag))) else $error("flow changed");
	ready_after_reset_a: assert property ($rose(rst_n_i) |-> ready && !valid)
		else $error("link busy after reset");
endmodule // fh_link_props

// [testbench.sv]
// Bench joining framer and reassembler over the link
`timescale 1ns/1ps
module testbench;
	logic mclk_i = 1'b0; // Packet clock
	logic rst_n_i = 1'b0; // Reset, active low
	logic [7:0] addr = 8'h00; // Register bus
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'hf;
	logic [31:0] rdat;
	logic waitreq;
	logic m_valid = 1'b0; // Message input
	logic m_ready;
	logic [7:0] m_data = 8'h00;
	logic m_last = 1'b0;
	logic m_plane = 1'b0;
	logic [15:0] m_ac = 16'h0;
	logic [11:0] m_sect = 12'h0;
	logic [9:0] m_blk = 10'h0;
	logic [15:0] cu_tag = 16'h0; // Receiver setup
	logic bb_role = 1'b0;
	logic o_valid, o_last, loss, mgmt, o_valid_b, o_last_b, loss_b, mgmt_b;
	logic [7:0] o_data, o_seq;
	logic [7:0] o_data_b; // Second receiver byte
	logic o_rdy = 1'b1; // Output ready of both receivers
	int n_mgmt_b = 0;
	logic [7:0] rxd_b[$]; // Bytes delivered by second receiver
	logic [31:0] o_ep;
	int n_errors = 0;
	int total_checks = 0;
	int n_mgmt = 0;
	int n_loss_b = 0;
	int n_out_b = 0;
	typedef struct packed {
		logic [7:0] seq; logic e; logic [6:0] sub; logic [11:0] sect;
		logic [9:0] fbi; logic [9:0] cnt; logic [15:0] tag; logic [1:0] kind;
	} pkt_s;
	pkt_s lq[$]; // Packets seen on the link
	logic [7:0] rxd[$]; // Bytes delivered
	logic [7:0] rxs[$]; // Sequence per delivered message
	logic [31:0] rxe[$]; // Endpoint per delivered message
	fh_link_if lk();
	fh_link_if lk2(); // Driven by the bench to break the rules
	fh_framer_tx #(.NUM_FLOWS(16), .BLOCK_BYTES(4)) i_fh_framer_tx (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
		.avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
		.avs_waitrequest_o(waitreq), .msg_valid_i(m_valid), .msg_ready_o(m_ready),
		.msg_data_i(m_data), .msg_last_i(m_last), .msg_plane_i(m_plane),
		.antenna_carrier_id_i(m_ac), .section_tag_i(m_sect), .first_block_index_i(m_blk),
		.link(lk));
	fh_reassembler_rx #(.DEPTH(64)) i_fh_reassembler_rx (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.link(lk), .cu_tag_i(cu_tag), .baseband_role_i(bb_role), .out_valid_o(o_valid),
		.out_ready_i(o_rdy), .out_data_o(o_data), .out_last_o(o_last),
		.out_antenna_carrier_id_o(), .out_endpoint_o(o_ep),
		.out_message_sequence_number_o(o_seq), .loss_o(loss), .mgmt_o(mgmt));
	fh_reassembler_rx #(.DEPTH(64)) i_fh_reassembler_rx_b (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .link(lk2), .cu_tag_i(cu_tag), .baseband_role_i(bb_role),
		.out_valid_o(o_valid_b), .out_ready_i(o_rdy), .out_data_o(o_data_b),
		.out_last_o(o_last_b),
		.out_antenna_carrier_id_o(), .out_endpoint_o(), .out_message_sequence_number_o(),
		.loss_o(loss_b), .mgmt_o(mgmt_b));
	fh_link_props #(.LIMIT(8)) i_fh_link_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.valid(lk.valid), .ready(lk.ready), .data(lk.data), .last(lk.last), .plane(lk.plane),
		.antenna_carrier_id(lk.antenna_carrier_id), .flow_tag(lk.flow_tag),
		.message_sequence_number(lk.message_sequence_number),
		.last_fragment(lk.last_fragment), .fragment_sequence_number(lk.fragment_sequence_number));
	// Clock, 100 ns period
	initial begin
		forever #50 mclk_i = ~mclk_i;
	end
	// Start values of the faulty link
	initial begin
		lk2.valid = 1'b0;
		lk2.last = 1'b1;
		lk2.data = 8'h00;
		lk2.plane = 1'b0;
		lk2.antenna_carrier_id = 16'h0;
		lk2.message_sequence_number = 8'h00;
		lk2.last_fragment = 1'b0;
		lk2.fragment_sequence_number = 7'h0;
		lk2.section_tag = 12'h0;
		lk2.first_block_index = 10'h0;
		lk2.block_count = 10'h0;
		lk2.flow_tag = 16'h0;
		lk2.tag_kind = 2'h0;
	end
	// Monitors of link and outputs
	always @(posedge mclk_i) begin
		if (lk.valid && lk.ready && lk.last) begin
			lq.push_back({lk.message_sequence_number, lk.last_fragment,
				lk.fragment_sequence_number, lk.section_tag, lk.first_block_index,
				lk.block_count, lk.flow_tag, lk.tag_kind});
		end
		if (o_valid) rxd.push_back(o_data);
		if (o_valid && o_last) begin
			rxs.push_back(o_seq);
			rxe.push_back(o_ep);
		end
		if (mgmt) n_mgmt++;
		if (loss_b) n_loss_b++;
		if (mgmt_b) n_mgmt_b++;
		if (o_valid_b && o_rdy) rxd_b.push_back(o_data_b);
		if (o_valid_b && o_last_b && o_rdy) n_out_b++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge mclk_i);
		addr <= a;
		wdat <= d;
		be <= b;
		wr_en <= 1'b1;
		// Held until an edge samples waitrequest low
		do @(posedge mclk_i); while (waitreq !== 1'b0);
		wr_en <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		addr <= a;
		rd_en <= 1'b1;
		// Data taken at the edge that sees waitrequest low
		do @(posedge mclk_i); while (waitreq !== 1'b0);
		chk(rdat, exp);
		rd_en <= 1'b0;
	endtask
	task automatic send(input logic p, input logic [15:0] ac, input int n, input logic [7:0] b);
		@(posedge mclk_i);
		for (int i = 0; i < n; i++) begin
			m_valid <= 1'b1;
			m_data <= b + 8'(i);
			m_last <= (i == n - 1);
			m_plane <= p;
			m_ac <= ac;
			// Byte taken at the edge that sees ready high
			do @(posedge mclk_i); while (m_ready !== 1'b1);
		end
		m_valid <= 1'b0;
	endtask
	task automatic drv(input logic [6:0] sub, input logic e, input logic [7:0] seq,
		input logic l, input logic [15:0] tag, input logic [7:0] d);
		@(posedge mclk_i);
		lk2.valid <= 1'b1;
		lk2.fragment_sequence_number <= sub;
		lk2.last_fragment <= e;
		lk2.message_sequence_number <= seq;
		lk2.last <= l;
		lk2.flow_tag <= tag;
		lk2.data <= d;
		lk2.antenna_carrier_id <= {8'h00, seq};
		do @(posedge mclk_i); while (lk2.ready !== 1'b1);
		lk2.valid <= 1'b0;
	endtask
	task automatic clr;
		lq.delete();
		rxd.delete();
		rxs.delete();
		rxe.delete();
	endtask
	task automatic wait_rx(input int n);
		for (int i = 0; i < 400 && rxs.size() < n; i++) @(posedge mclk_i);
	endtask
	task automatic t_regs;
		rdchk(fh_pkg::REG_CTRL, fh_pkg::CTRL_RESET);
		rdchk(fh_pkg::REG_MTU, fh_pkg::MTU_RESET);
		rdchk(fh_pkg::REG_STATUS, 32'h0);
		wr(fh_pkg::REG_CTRL, 32'hffff_ffff, 4'hf);
		rdchk(fh_pkg::REG_CTRL, 32'h0000_0007);
		wr(fh_pkg::REG_MTU, 32'h0000_0004, 4'hf);
		rdchk(fh_pkg::REG_MTU, fh_pkg::MTU_RESET);
		wr(fh_pkg::REG_MTU, 32'hffff_0010, 4'h3);
		rdchk(fh_pkg::REG_MTU, 32'h0000_0010);
		wr(8'h0c, 32'h1234_5678, 4'hf);
		rdchk(8'h0c, 32'h0);
	endtask
	task automatic t_app;
		wr(fh_pkg::REG_CTRL, 32'h0, 4'hf);
		clr();
		m_sect <= 12'habc;
		m_blk <= 10'h005;
		send(1'b0, 16'h0001, 20, 8'h10);
		wait_rx(3);
		chk(lq.size(), 3);
		for (int k = 0; k < 3; k++) begin
			chk({lq[k].seq, lq[k].e, lq[k].sub}, {8'(k), 1'b1, 7'h0});
			chk({lq[k].sect, lq[k].fbi, lq[k].cnt}, {12'habc, 10'(5 + 2 * k), 10'(k < 2 ? 2 : 1)});
			chk(rxs[k], 8'(k));
			chk(rxe[k], 32'h0000_0001);
		end
		for (int i = 0; i < 20; i++) chk(rxd[i], 8'h10 + 8'(i));
		rdchk(fh_pkg::REG_STATUS, 32'h0000_0003);
	endtask
	task automatic t_trans;
		wr(fh_pkg::REG_CTRL, 32'h1, 4'hf);
		clr();
		send(1'b0, 16'h0001, 20, 8'h40);
		wait_rx(1);
		chk(lq.size(), 3);
		for (int k = 0; k < 3; k++) begin
			chk({lq[k].seq, lq[k].e, lq[k].sub}, {8'h03, k == 2, 7'(k)});
		end
		chk(rxs[0], 8'h03);
		for (int i = 0; i < 20; i++) chk(rxd[i], 8'h40 + 8'(i));
		rdchk(fh_pkg::REG_STATUS, 32'h0000_0004);
	endtask
	task automatic t_flows;
		wr(8'h18, 32'h0000_1234, 4'hf);
		rdchk(8'h18, 32'h0000_1234);
		clr();
		for (int k = 0; k < 4; k++) begin
			wr(fh_pkg::REG_CTRL, 32'(2 * k + 1), 4'hf);
			send(1'b0, 16'h0002, 1, 8'(k));
			for (int i = 0; i < 50 && lq.size() <= k; i++) @(posedge mclk_i);
			chk({lq[k].tag, lq[k].kind, lq[k].seq}, {16'h1234, 2'(k), 8'(k)});
		end
		cu_tag <= 16'h1234;
		bb_role <= 1'b1;
		send(1'b0, 16'h0002, 1, 8'h78);
		send(1'b1, 16'h0002, 1, 8'h77);
		wait_rx(2);
		chk({lq[4].seq, lq[5].seq}, {8'h04, 8'h00});
		chk(n_mgmt, 4);
		chk(rxe[1], 32'h1234_0002);
	endtask
	task automatic t_wrap;
		cu_tag <= 16'h0;
		bb_role <= 1'b0;
		clr();
		for (int k = 0; k < 257; k++) send(1'b0, 16'h0003, 1, 8'(k));
		wait_rx(257);
		chk({lq[255].seq, lq[256].seq}, {8'hff, 8'h00});
		chk(rxs[256], 8'h00);
	endtask
	task automatic t_loss;
		drv(7'h1, 1'b1, 8'h00, 1'b1, 16'h0000, 8'h01); // First piece missing
		drv(7'h0, 1'b1, 8'h00, 1'b0, 16'h0000, 8'ha0); // Two-byte whole message
		drv(7'h0, 1'b1, 8'h00, 1'b1, 16'h0000, 8'ha1);
		drv(7'h0, 1'b0, 8'h00, 1'b1, 16'h0000, 8'h02);
		drv(7'h0, 1'b0, 8'h00, 1'b1, 16'h0055, 8'h03); // Other flow, ignored
		drv(7'h2, 1'b1, 8'h00, 1'b1, 16'h0000, 8'h04); // Gap in numbering
		drv(7'h0, 1'b0, 8'h01, 1'b1, 16'h0000, 8'h05);
		drv(7'h1, 1'b1, 8'h02, 1'b1, 16'h0000, 8'h06); // Sequence changes mid message
		drv(7'h0, 1'b0, 8'h03, 1'b1, 16'h0000, 8'hb0);
		o_rdy <= 1'b0;
		drv(7'h1, 1'b1, 8'h03, 1'b1, 16'h0000, 8'hb1);
		// First byte must stand while output is held off
		repeat (4) @(posedge mclk_i);
		chk({o_valid_b, o_data_b}, {1'b1, 8'hb0});
		o_rdy <= 1'b1;
		for (int i = 0; i < 50 && n_out_b < 2; i++) @(posedge mclk_i);
		chk(n_loss_b, 3);
		chk(n_out_b, 2);
		chk(n_mgmt_b, 1);
		chk({rxd_b[0], rxd_b[1], rxd_b[2], rxd_b[3]}, 32'ha0a1_b0b1);
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_app();
		t_trans();
		t_flows();
		t_wrap();
		t_loss();
		report_and_stop();
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_errors++;
		report_and_stop();
	end
endmodule // testbench
